// [verilog/vt_adc_pkg.sv]
// shared constants for the voltage and temperature converter control block
package vt_adc_pkg;
	// register byte addresses
	localparam logic [31:0] CTRL_ADDR = 32'h40030010;
	localparam logic [31:0] IRQ_STATUS_ADDR = 32'h40030020;
	localparam logic [31:0] IRQ_MASK_ADDR = 32'h40030024;
	localparam logic [31:0] STATE_ADDR = 32'h40030028;
	// reset values
	localparam logic [31:0] CTRL_RESET = 32'h00000000;
	localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
	// control register field positions
	localparam int ENABLE_BIT = 19;
	localparam int BYPASS_LSB = 16;
	localparam int DIAG_LSB = 12;
	localparam int CODING_BIT = 9;
	localparam int CHANNEL_LSB = 6;
	localparam int REF_BIT = 4;
	// interrupt status bit positions
	localparam int EV_VOLT_BIT = 0;
	localparam int EV_TEMP_BIT = 1;
	localparam int EV_SETTLED_BIT = 2;
	localparam int EV_WIDTH = 3;
	// settling length in current converter conversion periods
	localparam int SETTLE_CONVERSIONS = 4;
	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [verilog/vt_restart_sequencer.sv]
// restart and settling sequencer for the voltage and temperature converter
`timescale 1ns/1ns
`default_nettype none
module vt_restart_sequencer #(
	parameter int SETTLE_CONV = vt_adc_pkg::SETTLE_CONVERSIONS
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic reset_n_in,
	// control
	input wire logic enable_in,
	input wire logic restart_in,
	input wire logic conv_sync_in,
	// status
	output logic conv_reset_out,
	output logic settled_out,
	output logic settle_done_out
);
	import vt_adc_pkg::*;

	typedef enum logic [1:0] {SEQ_OFF, SEQ_WAIT_SYNC, SEQ_SETTLE, SEQ_RUN} seq_state_t;

	seq_state_t state_q;
	seq_state_t state_d;
	logic [7:0] count_q;
	logic [7:0] count_d;
	logic done_d;

	if (SETTLE_CONV < 1 || SETTLE_CONV > 255) begin
		$error("settle count out of range");
	end

	always_comb begin
		state_d = state_q;
		count_d = count_q;
		done_d = 1'b0;
		if (!enable_in) begin
			state_d = SEQ_OFF;
		end else if (restart_in) begin
			state_d = SEQ_WAIT_SYNC;
		end else begin
			case (state_q)
				SEQ_OFF: begin
					state_d = SEQ_WAIT_SYNC;
				end
				SEQ_WAIT_SYNC: begin
					// leave reset only on a current converter boundary
					if (conv_sync_in) begin
						state_d = SEQ_SETTLE;
						count_d = 8'h00;
					end
				end
				SEQ_SETTLE: begin
					if (conv_sync_in) begin
						if (count_q == 8'(SETTLE_CONV - 1)) begin
							state_d = SEQ_RUN;
							done_d = 1'b1;
						end else begin
							count_d = count_q + 8'h01;
						end
					end
				end
				SEQ_RUN: begin
					state_d = SEQ_RUN;
				end
				default: begin
					state_d = SEQ_OFF;
				end
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			state_q <= SEQ_OFF;
			count_q <= 8'h00;
			conv_reset_out <= 1'b1;
			settled_out <= 1'b0;
			settle_done_out <= 1'b0;
		end else begin
			state_q <= state_d;
			count_q <= count_d;
			conv_reset_out <= (state_d == SEQ_OFF) || (state_d == SEQ_WAIT_SYNC);
			settled_out <= (state_d == SEQ_RUN);
			settle_done_out <= done_d;
		end
	end

	chk_settle_needs_syncs: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		$rose(settled_out) |-> !conv_reset_out && $past(conv_sync_in))
		else $error("settled without a final sync");
	cover_settle_reached: cover property (@(posedge clk_in) disable iff (!reset_n_in)
		$rose(settled_out));
endmodule
`default_nettype wire

// [verilog/vt_converter_control.sv]
// control register and result gating for the voltage and temperature converter
//
// Summary of operation
// - any software write to the control register resets the converter
// - converter leaves reset on a current converter conversion boundary, staying synchronous
// - control changes never reset or disturb the current converter
// - no result shown ready until the full filter settling has elapsed
// - control register resets to zero, converter powered down
// - bit 19 enables; clear powers down and clears both ready flags
// - bits 17:16 choose which input buffers are bypassed
// - bits 13:12 steer the 50 uA diagnostic current to the inputs
// - bit 9 one gives unipolar coding; negative results become zero
// - bits 8:6 select one of eight input channels
// - bit 4 selects internal 1.2 V or supply against switched ground
`timescale 1ns/1ns
`default_nettype none
module vt_converter_control #(
	parameter int RESULT_W = 24,
	parameter int SETTLE_CONV = vt_adc_pkg::SETTLE_CONVERSIONS
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic reset_n_in,
	// axi4-lite write address and data
	input wire logic [31:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	// axi4-lite read
	input wire logic [31:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	// converter side, same clock domain
	input wire logic conv_sync_in,
	input wire logic voltage_done_in,
	input wire logic [RESULT_W-1:0] voltage_raw_in,
	input wire logic temperature_done_in,
	input wire logic [RESULT_W-1:0] temperature_raw_in,
	// converter configuration
	output logic voltage_temp_converter_enable_out,
	output logic voltage_temp_converter_reset_out,
	output logic [1:0] input_buffer_bypass_out,
	output logic [1:0] diagnostic_current_select_out,
	output logic output_coding_select_out,
	output logic [2:0] input_channel_select_out,
	output logic reference_select_out,
	// results and interrupt
	output logic [RESULT_W-1:0] voltage_result_out,
	output logic [RESULT_W-1:0] temperature_result_out,
	output logic voltage_result_ready_out,
	output logic temperature_result_ready_out,
	output logic irq_out
);
	import vt_adc_pkg::*;

	logic [31:0] ctrl_q;
	logic [EV_WIDTH-1:0] irq_status_q;
	logic [EV_WIDTH-1:0] irq_mask_q;
	logic aw_held_q;
	logic w_held_q;
	logic [31:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic restart_q;
	logic do_write;
	logic wr_ctrl;
	logic rd_take;
	logic [31:0] rdata_d;
	logic [1:0] rresp_d;
	logic settled_w;
	logic settle_done_w;
	logic accept_w;
	logic [EV_WIDTH-1:0] events_w;

	if (RESULT_W < 2 || RESULT_W > 32) begin
		$error("result width out of range");
	end

	// merge bytes of a write into the old value under its strobes
	function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
			input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// unipolar coding floors negative results at zero
	function automatic logic [RESULT_W-1:0] code_result(input logic [RESULT_W-1:0] raw,
			input logic unipolar);
		if (unipolar && raw[RESULT_W-1]) begin
			return '0;
		end
		return raw;
	endfunction

	assign do_write = aw_held_q && w_held_q && !s_axi_bvalid_out;
	assign wr_ctrl = do_write && (awaddr_q == CTRL_ADDR);
	assign rd_take = s_axi_arvalid_in && s_axi_arready_out;
	// settled lags a restart by one edge, so the pending restart blocks results too
	assign accept_w = ctrl_q[ENABLE_BIT] && settled_w && !restart_q;

	// write channels are taken independently, in either order
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			awaddr_q <= 32'h00000000;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
			s_axi_awready_out <= 1'b1;
			s_axi_wready_out <= 1'b1;
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid_in && s_axi_awready_out) begin
				aw_held_q <= 1'b1;
				awaddr_q <= s_axi_awaddr_in;
				s_axi_awready_out <= 1'b0;
			end
			if (s_axi_wvalid_in && s_axi_wready_out) begin
				w_held_q <= 1'b1;
				wdata_q <= s_axi_wdata_in;
				wstrb_q <= s_axi_wstrb_in;
				s_axi_wready_out <= 1'b0;
			end
			if (do_write) begin
				aw_held_q <= 1'b0;
				w_held_q <= 1'b0;
				s_axi_bvalid_out <= 1'b1;
				if (awaddr_q == CTRL_ADDR || awaddr_q == IRQ_MASK_ADDR) begin
					s_axi_bresp_out <= RESP_OKAY;
				end else begin
					s_axi_bresp_out <= RESP_SLVERR;
				end
			end
			if (s_axi_bvalid_out && s_axi_bready_in) begin
				s_axi_bvalid_out <= 1'b0;
				s_axi_awready_out <= 1'b1;
				s_axi_wready_out <= 1'b1;
			end
		end
	end

	// control register; the current converter has no path from here
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			ctrl_q <= CTRL_RESET;
			restart_q <= 1'b0;
		end else begin
			restart_q <= wr_ctrl;
			if (wr_ctrl) begin
				ctrl_q <= apply_strb(ctrl_q, wdata_q, wstrb_q);
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			irq_mask_q <= IRQ_MASK_RESET;
		end else if (do_write && awaddr_q == IRQ_MASK_ADDR && wstrb_q[0]) begin
			irq_mask_q <= wdata_q[EV_WIDTH-1:0];
		end
	end

	// configuration outputs taken straight from the register bits
	assign voltage_temp_converter_enable_out = ctrl_q[ENABLE_BIT];
	assign input_buffer_bypass_out = ctrl_q[BYPASS_LSB +: 2];
	assign diagnostic_current_select_out = ctrl_q[DIAG_LSB +: 2];
	assign output_coding_select_out = ctrl_q[CODING_BIT];
	assign input_channel_select_out = ctrl_q[CHANNEL_LSB +: 3];
	assign reference_select_out = ctrl_q[REF_BIT];

	vt_restart_sequencer #(
		.SETTLE_CONV(SETTLE_CONV)
	) u_sequencer (
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.enable_in(ctrl_q[ENABLE_BIT]),
		.restart_in(restart_q),
		.conv_sync_in(conv_sync_in),
		.conv_reset_out(voltage_temp_converter_reset_out),
		.settled_out(settled_w),
		.settle_done_out(settle_done_w)
	);

	// results only pass once settled; a restart drops stale flags
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			voltage_result_ready_out <= 1'b0;
			temperature_result_ready_out <= 1'b0;
			voltage_result_out <= '0;
			temperature_result_out <= '0;
		end else if (!accept_w) begin
			voltage_result_ready_out <= 1'b0;
			temperature_result_ready_out <= 1'b0;
		end else begin
			if (voltage_done_in) begin
				voltage_result_ready_out <= 1'b1;
				voltage_result_out <= code_result(voltage_raw_in, ctrl_q[CODING_BIT]);
			end
			if (temperature_done_in) begin
				temperature_result_ready_out <= 1'b1;
				temperature_result_out <= code_result(temperature_raw_in,
					ctrl_q[CODING_BIT]);
			end
		end
	end

	// sticky events; a fresh event wins over the read that clears
	always_comb begin
		events_w = '0;
		events_w[EV_VOLT_BIT] = voltage_done_in && accept_w;
		events_w[EV_TEMP_BIT] = temperature_done_in && accept_w;
		events_w[EV_SETTLED_BIT] = settle_done_w;
	end

	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			irq_status_q <= '0;
		end else if (rd_take && s_axi_araddr_in == IRQ_STATUS_ADDR) begin
			irq_status_q <= events_w;
		end else begin
			irq_status_q <= irq_status_q | events_w;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= |(irq_status_q & irq_mask_q);
		end
	end

	always_comb begin
		rdata_d = 32'h00000000;
		rresp_d = RESP_OKAY;
		case (s_axi_araddr_in)
			CTRL_ADDR: begin
				rdata_d = ctrl_q;
			end
			IRQ_STATUS_ADDR: begin
				rdata_d[EV_WIDTH-1:0] = irq_status_q;
			end
			IRQ_MASK_ADDR: begin
				rdata_d[EV_WIDTH-1:0] = irq_mask_q;
			end
			STATE_ADDR: begin
				rdata_d[3:0] = {settled_w, voltage_temp_converter_reset_out,
					temperature_result_ready_out, voltage_result_ready_out};
			end
			default: begin
				rresp_d = RESP_SLVERR;
			end
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			s_axi_arready_out <= 1'b1;
			s_axi_rvalid_out <= 1'b0;
			s_axi_rdata_out <= 32'h00000000;
			s_axi_rresp_out <= RESP_OKAY;
		end else if (rd_take) begin
			s_axi_arready_out <= 1'b0;
			s_axi_rvalid_out <= 1'b1;
			s_axi_rdata_out <= rdata_d;
			s_axi_rresp_out <= rresp_d;
		end else if (s_axi_rvalid_out && s_axi_rready_in) begin
			s_axi_rvalid_out <= 1'b0;
			s_axi_arready_out <= 1'b1;
		end
	end

	chk_write_resets_conv: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		wr_ctrl |-> ##2 voltage_temp_converter_reset_out)
		else $error("control write did not reset converter");
	chk_restart_on_sync: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		$fell(voltage_temp_converter_reset_out) |-> $past(conv_sync_in))
		else $error("converter restarted off a sync boundary");
	chk_ready_needs_settle: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		$rose(voltage_result_ready_out) |-> $past(settled_w) && $past(voltage_done_in))
		else $error("voltage ready before settling");
	chk_reset_clears_ctrl: assert property (@(posedge clk_in)
		!reset_n_in |=> ctrl_q == CTRL_RESET && !voltage_temp_converter_enable_out)
		else $error("control register not zero after reset");
	chk_disable_clears_rdy: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		!voltage_temp_converter_enable_out |=> !voltage_result_ready_out
		&& !temperature_result_ready_out)
		else $error("ready flag survived power down");
	chk_bypass_field: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		wr_ctrl && wstrb_q[2] |=> input_buffer_bypass_out == $past(wdata_q[17:16]))
		else $error("bypass field not taken from write");
	chk_channel_field: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		wr_ctrl && wstrb_q[0] && wstrb_q[1] |=>
		input_channel_select_out == $past(wdata_q[8:6]))
		else $error("channel field not taken from write");
	chk_unipolar_clamp: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		voltage_done_in && accept_w && ctrl_q[CODING_BIT]
		&& voltage_raw_in[RESULT_W-1] |=> voltage_result_out == '0)
		else $error("negative result not floored in unipolar mode");
	chk_ctrl_readback: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		rd_take && s_axi_araddr_in == CTRL_ADDR |=> s_axi_rvalid_out
		&& s_axi_rdata_out == $past(ctrl_q))
		else $error("control read back mismatch");

	cover_ctrl_write: cover property (@(posedge clk_in) disable iff (!reset_n_in) wr_ctrl);
	cover_voltage_ready: cover property (@(posedge clk_in) disable iff (!reset_n_in)
		$rose(voltage_result_ready_out));
	cover_irq_raised: cover property (@(posedge clk_in) disable iff (!reset_n_in)
		$rose(irq_out));
endmodule
`default_nettype wire

// [test/testbench.sv]
// self-checking bench for the converter control register block
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import vt_adc_pkg::*;
	// short settling so the run stays brief
	localparam int SETTLE = 2;
	logic clk_in, reset_n_in;
	logic [31:0] awaddr, wdata, araddr, rdata, rd_v, d, cfg_seen;
	logic [3:0] wstrb;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [1:0] bresp, rresp, bs_v, rs_v, bypass, diag;
	logic sync, vdone, tdone, en, crst, coding, refsel, vrdy, trdy, irq;
	logic [2:0] chan;
	logic [23:0] vraw, traw, vres, tres;
	int miscompares = 0;
	int tests_run = 0;
	int cycles = 0;

	vt_converter_control #(.RESULT_W(24), .SETTLE_CONV(SETTLE)) u_dut (
		.clk_in(clk_in), .reset_n_in(reset_n_in),
		.s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
		.s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
		.s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
		.s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
		.s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
		.s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .conv_sync_in(sync),
		.voltage_done_in(vdone), .voltage_raw_in(vraw), .temperature_done_in(tdone),
		.temperature_raw_in(traw), .voltage_temp_converter_enable_out(en),
		.voltage_temp_converter_reset_out(crst), .input_buffer_bypass_out(bypass),
		.diagnostic_current_select_out(diag), .output_coding_select_out(coding),
		.input_channel_select_out(chan), .reference_select_out(refsel),
		.voltage_result_out(vres), .temperature_result_out(tres),
		.voltage_result_ready_out(vrdy), .temperature_result_ready_out(trdy), .irq_out(irq)
	);

	assign cfg_seen = {22'h0, en, bypass, diag, coding, chan, refsel};

	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end

	function automatic logic [31:0] cfg_exp(input logic [31:0] v);
		return {22'h0, v[19], v[17:16], v[13:12], v[9], v[8:6], v[4]};
	endfunction

	task check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task results;
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// address and data offered together, each released once taken
	task automatic axi_write(input logic [31:0] a, input logic [31:0] v, input logic [3:0] s);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge clk_in);
		awaddr <= a;
		wdata <= v;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge clk_in);
			if (!aw_ok && awready === 1'b1) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_ok && wready === 1'b1) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge clk_in); while (bvalid !== 1'b1);
		bs_v = bresp;
		bready <= 1'b0;
		#1;
	endtask

	task automatic axi_read(input logic [31:0] a);
		@(posedge clk_in);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk_in); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk_in); while (rvalid !== 1'b1);
		rd_v = rdata;
		rs_v = rresp;
		rready <= 1'b0;
		#1;
	endtask

	// sync pulses stay one cycle apart
	task automatic pulse_sync(input int n);
		repeat (n) begin
			@(posedge clk_in);
			sync <= 1'b1;
			@(posedge clk_in);
			sync <= 1'b0;
		end
		repeat (2) @(posedge clk_in);
		#1;
	endtask

	task automatic pulse_done(input logic v, input logic t, input logic [23:0] raw);
		@(posedge clk_in);
		vdone <= v;
		tdone <= t;
		vraw <= raw;
		traw <= raw;
		@(posedge clk_in);
		vdone <= 1'b0;
		tdone <= 1'b0;
		repeat (2) @(posedge clk_in);
		#1;
	endtask

	// hang guard, well above the expected run length
	always @(posedge clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares++;
			results();
		end
	end

	initial begin
		reset_n_in = 1'b0;
		{awaddr, wdata, araddr, wstrb, awvalid, wvalid, bready, arvalid, rready} = '0;
		{sync, vdone, tdone, vraw, traw} = '0;
		repeat (6) @(posedge clk_in);
		reset_n_in <= 1'b1;
		@(posedge clk_in);
		#1;
		check(cfg_seen, 32'h0);
		check({28'h0, crst, vrdy, trdy, irq}, 32'h8);
		axi_read(CTRL_ADDR);
		check(rd_v, CTRL_RESET);
		// every field value, reserved bits on odd passes; supply reference leans on a board resistor
		for (int i = 0; i < 8; i++) begin
			d = {12'h0, i[2], 1'b0, i[1:0], 2'h0, i[1:0], 2'h0, i[0], i[2:0], 1'b0, i[1], 4'h0};
			if (i[0]) begin
				d = d | 32'h0004CC2F;
			end
			axi_write(CTRL_ADDR, d, 4'hF);
			check(cfg_seen, cfg_exp(d));
			axi_read(CTRL_ADDR);
			check(rd_v, d);
		end
		// enabled, unipolar, internal temperature channel
		axi_write(CTRL_ADDR, 32'h00080280, 4'hF);
		check({31'h0, crst}, 32'h1);
		pulse_sync(1);
		check({31'h0, crst}, 32'h0);
		pulse_done(1'b1, 1'b0, 24'h000055);
		check({30'h0, vrdy, trdy}, 32'h0);
		pulse_sync(SETTLE);
		check({30'h0, vrdy, trdy}, 32'h0);
		pulse_done(1'b1, 1'b0, 24'hFFFF00);
		pulse_done(1'b0, 1'b1, 24'h001234);
		check({30'h0, vrdy, trdy}, 32'h3);
		check({8'h0, vres}, 32'h0);
		check({8'h0, tres}, 32'h00001234);
		axi_read(STATE_ADDR);
		check(rd_v, 32'hB);
		check({31'h0, irq}, 32'h0);
		// unmask only the voltage event, then clear by reading
		axi_write(IRQ_MASK_ADDR, 32'h1, 4'hF);
		check({31'h0, irq}, 32'h1);
		axi_read(IRQ_STATUS_ADDR);
		check(rd_v, 32'h7);
		@(posedge clk_in);
		#1;
		check({31'h0, irq}, 32'h0);
		axi_read(IRQ_STATUS_ADDR);
		check(rd_v, 32'h0);
		// empty strobe still restarts, value kept
		axi_write(CTRL_ADDR, 32'h0, 4'h0);
		check({29'h0, crst, vrdy, trdy}, 32'h4);
		axi_read(CTRL_ADDR);
		check(rd_v, 32'h00080280);
		pulse_sync(1 + SETTLE);
		pulse_done(1'b1, 1'b1, 24'h000100);
		check({30'h0, vrdy, trdy}, 32'h3);
		check({8'h0, vres}, 32'h00000100);
		// power down into hibernate drops both ready flags
		axi_write(CTRL_ADDR, 32'h00030000, 4'hF);
		check({29'h0, en, vrdy, trdy}, 32'h0);
		check({30'h0, bypass}, 32'h3);
		// unmapped place
		axi_write(32'h40030014, 32'hFFFFFFFF, 4'hF);
		check({30'h0, bs_v}, {30'h0, RESP_SLVERR});
		axi_read(32'h40030014);
		check(rd_v, 32'h0);
		check({30'h0, rs_v}, {30'h0, RESP_SLVERR});
		axi_read(CTRL_ADDR);
		check(rd_v, 32'h00030000);
		results();
	end
endmodule
`default_nettype wire
